// >>> can_filter_defines.svh
// Register offsets, field positions and reset values for the acceptance filter block.
`ifndef CAN_FILTER_DEFINES_SVH
`define CAN_FILTER_DEFINES_SVH

`define CF_ADDR_W 8
`define CF_CTRL_BASE 8'h00
`define CF_MASK_BASE 8'h10
`define CF_ID_BASE 8'h20
`define CF_STATUS 8'h60
`define CF_WORD_SHIFT 2
`define CF_NUM_MASKS 4
`define CF_FILTERS_PER_REG 4
`define CF_BYTE_W 8
`define CF_EN_BIT 7
`define CF_MSEL_HI 6
`define CF_MSEL_LO 5
`define CF_FSEL_HI 4
`define CF_FSEL_LO 0
`define CF_MSEL_W 2
`define CF_FSEL_W 5
`define CF_ACCEPT_W 11
`define CF_ID_W 29
`define CF_CTRL_RESET 8'h00
`define CF_MASK_RESET 29'h0000_0000
`define CF_ID_RESET 29'h0000_0000

`endif

// >>> can_filter_pkg.sv
// Types shared by the acceptance filter block and its surroundings.
package can_filter_pkg;

	typedef struct packed {
		logic valid;
		logic [28:0] id;
	} rx_id_t;

	typedef struct packed {
		logic hit;
		logic [4:0] fifo;
		logic [4:0] filter;
	} accept_t;

	typedef struct packed {
		logic enable;
		logic [1:0] mask_choice;
		logic [4:0] fifo_choice;
	} filter_ctrl_t;

endpackage : can_filter_pkg

// >>> can_acceptance_filter_control.sv
// Acceptance filter configuration registers and receive-identifier steering.
// Notes on behaviour
// - A filter takes part in acceptance only while its enable flag is 1.
// - The two-bit mask choice selects acceptance mask 0, 1, 2 or 3 for the filter.
// - The five-bit FIFO choice names the receive FIFO 0 to 31 that takes a matching message.
// - Mask and FIFO choices of a filter change only while that filter's enable flag is 0.
// - Each filter owns one byte: enable on top, mask choice next two bits, FIFO choice low five.
// - Control register 0 holds filters 0 to 3 with filter 3 on top, register 2 holds 8 and 9 low.
// - All control fields are read/write and reset to zero, leaving every filter disabled.
`timescale 1ns/1ps
`include "can_filter_defines.svh"

module can_acceptance_filter_control #(
	parameter int NUM_FILTERS = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic [`CF_ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rd_data,
	input wire can_filter_pkg::rx_id_t i_rx,
	output can_filter_pkg::accept_t o_accept
);

	localparam int NUM_CTRL = (NUM_FILTERS + `CF_FILTERS_PER_REG - 1) / `CF_FILTERS_PER_REG;
	localparam int IDX_W = (NUM_FILTERS > 1) ? $clog2(NUM_FILTERS) : 1;

	can_filter_pkg::filter_ctrl_t ctrl_r [NUM_FILTERS];
	logic [`CF_ID_W-1:0] mask_r [`CF_NUM_MASKS];
	logic [`CF_ID_W-1:0] fid_r [NUM_FILTERS];
	can_filter_pkg::accept_t accept_nxt;
	logic [31:0] rd_nxt;
	logic [5:0] word_idx;
	logic ctrl_region;
	logic mask_region;
	logic fid_region;
	logic stat_region;
	logic [NUM_FILTERS-1:0] ctrl_sel;
	logic [NUM_FILTERS-1:0] fid_sel;
	logic [NUM_FILTERS-1:0] match;

	// Lowest bit of filter f's byte within its control register.
	function automatic int lane_of(input int f);
		lane_of = (f % `CF_FILTERS_PER_REG) * `CF_BYTE_W;
	endfunction : lane_of

	// True when an address lies in the half-open range from base up to limit.
	function automatic logic in_range(input logic [`CF_ADDR_W-1:0] addr,
		input logic [`CF_ADDR_W-1:0] base, input logic [`CF_ADDR_W-1:0] limit);
		in_range = (addr >= base) && (addr < limit);
	endfunction : in_range

	// Explicit decode of the two-bit mask choice into one of the four masks.
	function automatic logic [`CF_ID_W-1:0] pick_mask(input logic [1:0] sel,
		input logic [`CF_ID_W-1:0] m0, input logic [`CF_ID_W-1:0] m1,
		input logic [`CF_ID_W-1:0] m2, input logic [`CF_ID_W-1:0] m3);
		case (sel)
			2'h0: pick_mask = m0;
			2'h1: pick_mask = m1;
			2'h2: pick_mask = m2;
			2'h3: pick_mask = m3;
			default: pick_mask = m0;
		endcase
	endfunction : pick_mask

	// Word index of a byte address relative to a region base.
	function automatic logic [5:0] word_of(input logic [`CF_ADDR_W-1:0] addr,
		input logic [`CF_ADDR_W-1:0] base);
		logic [`CF_ADDR_W-1:0] diff;
		diff = addr - base;
		word_of = diff[`CF_ADDR_W-1:`CF_WORD_SHIFT];
	endfunction : word_of

	// An identifier matches when every bit kept by the mask agrees with the filter value.
	function automatic logic id_match(input logic [`CF_ID_W-1:0] id,
		input logic [`CF_ID_W-1:0] fid, input logic [`CF_ID_W-1:0] msk);
		id_match = (((id ^ fid) & msk) == '0);
	endfunction : id_match

	assign word_idx = word_of(i_addr, `CF_CTRL_BASE);
	assign ctrl_region = in_range(i_addr, `CF_CTRL_BASE, `CF_MASK_BASE) &&
		(word_idx < 6'(NUM_CTRL));
	assign mask_region = in_range(i_addr, `CF_MASK_BASE, `CF_ID_BASE);
	assign fid_region = in_range(i_addr, `CF_ID_BASE, `CF_STATUS);
	assign stat_region = (i_addr == `CF_STATUS);

	// One select line per filter, shared by the write and read paths.
	always_comb begin
		for (int f = 0; f < NUM_FILTERS; f++) begin
			ctrl_sel[f] = ctrl_region && (word_idx == 6'(f / `CF_FILTERS_PER_REG));
			fid_sel[f] = fid_region && (word_of(i_addr, `CF_ID_BASE) == 6'(f));
		end
	end

	// Enable flag is always writable; the rest of a byte only while the filter is off.
	// Software that rewrites a live filter sees only the enable change, so it must clear
	// the enable first and write the new choices in a second access.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int f = 0; f < NUM_FILTERS; f++) begin
				ctrl_r[f] <= `CF_CTRL_RESET;
			end
		end else if (i_wr) begin
			for (int f = 0; f < NUM_FILTERS; f++) begin
				if (ctrl_sel[f]) begin
					// Filter f sits in byte f mod 4 of its register.
					ctrl_r[f].enable <= i_wr_data[lane_of(f) + `CF_EN_BIT];
					if (!ctrl_r[f].enable) begin
						ctrl_r[f].mask_choice <=
							i_wr_data[lane_of(f) + `CF_MSEL_LO +: `CF_MSEL_W];
						ctrl_r[f].fifo_choice <=
							i_wr_data[lane_of(f) + `CF_FSEL_LO +: `CF_FSEL_W];
					end
				end
			end
		end
	end

	// Masks are shared by all filters, so they carry no per-filter write guard.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int m = 0; m < `CF_NUM_MASKS; m++) begin
				mask_r[m] <= `CF_MASK_RESET;
			end
		end else if (i_wr && mask_region) begin
			mask_r[2'(word_of(i_addr, `CF_MASK_BASE))] <= i_wr_data[`CF_ID_W-1:0];
		end
	end

	// The filter value is guarded like the other filter settings so a live filter never
	// sees a half-updated comparison.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int f = 0; f < NUM_FILTERS; f++) begin
				fid_r[f] <= `CF_ID_RESET;
			end
		end else if (i_wr) begin
			for (int f = 0; f < NUM_FILTERS; f++) begin
				if (fid_sel[f] && !ctrl_r[f].enable) begin
					fid_r[f] <= i_wr_data[`CF_ID_W-1:0];
				end
			end
		end
	end

	// Per-filter match before priority; a disabled filter never takes part.
	// The match is combinational on the offered identifier, so an offer is answered in the
	// very next cycle whatever the number of filters.
	always_comb begin
		for (int f = 0; f < NUM_FILTERS; f++) begin
			match[f] = i_rx.valid && ctrl_r[f].enable &&
				id_match(i_rx.id, fid_r[f], pick_mask(ctrl_r[f].mask_choice,
				mask_r[0], mask_r[1], mask_r[2], mask_r[3]));
		end
	end

	// Scan from the top down so the lowest matching index is the one that remains.
	always_comb begin
		accept_nxt = '0;
		for (int f = NUM_FILTERS - 1; f >= 0; f--) begin
			if (match[f]) begin
				accept_nxt.hit = 1'b1;
				accept_nxt.fifo = ctrl_r[f].fifo_choice;
				accept_nxt.filter = 5'(f);
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_accept <= '0;
		end else begin
			o_accept <= accept_nxt;
		end
	end

	// Read decode; unmapped addresses read as zero.
	always_comb begin
		rd_nxt = '0;
		if (ctrl_region) begin
			for (int f = 0; f < NUM_FILTERS; f++) begin
				if (ctrl_sel[f]) begin
					rd_nxt[lane_of(f) +: `CF_BYTE_W] = ctrl_r[f];
				end
			end
		end else if (mask_region) begin
			rd_nxt[`CF_ID_W-1:0] = mask_r[2'(word_of(i_addr, `CF_MASK_BASE))];
		end else if (fid_region) begin
			for (int f = 0; f < NUM_FILTERS; f++) begin
				if (fid_sel[f]) begin
					rd_nxt[`CF_ID_W-1:0] = fid_r[f];
				end
			end
		end else if (stat_region) begin
			rd_nxt[`CF_ACCEPT_W-1:0] = o_accept;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rd_data <= '0;
		end else if (i_rd) begin
			o_rd_data <= rd_nxt;
		end else begin
			o_rd_data <= '0;
		end
	end

endmodule : can_acceptance_filter_control

// >>> can_rx_model.sv
// Receive-path model that offers identifiers to the filter block.
`timescale 1ns/1ps
module can_rx_model (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_req,
	input wire logic [28:0] i_id,
	output can_filter_pkg::rx_id_t o_rx
);
	// Idle id lines toggle, so a stale identifier never passes for a fresh one.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rx <= '0;
		end else begin
			o_rx.valid <= i_req;
			o_rx.id <= i_req ? i_id : ~o_rx.id;
		end
	end
endmodule : can_rx_model

// >>> can_filter_chk.sv
// Port checks of the acceptance filter block.
`timescale 1ns/1ps
module can_filter_chk #(
	parameter int NUM_FILTERS = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rd_data,
	input wire can_filter_pkg::rx_id_t i_rx,
	input wire can_filter_pkg::accept_t o_accept
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_wr0; i_wr && i_addr == 8'h00; endsequence
	sequence s_rd0; i_rd && i_addr == 8'h00; endsequence
	property p_rd_idle; !$past(i_rd) |-> o_rd_data == 32'h0000_0000; endproperty
	property p_acc_idle; !$past(i_rx.valid) |-> o_accept == '0; endproperty
	property p_miss_zero; !o_accept.hit |-> o_accept == '0; endproperty
	property p_hit_range; o_accept.hit |-> o_accept.filter < NUM_FILTERS; endproperty
	property p_en_wr; s_wr0 ##1 s_rd0 |=> (o_rd_data & 32'h8080_8080) ==
		($past(i_wr_data, 2) & 32'h8080_8080); endproperty
	property p_protect; s_rd0 ##1 (s_wr0 and o_rd_data[7]) ##1 s_rd0 |=>
		o_rd_data[6:0] == $past(o_rd_data[6:0], 2); endproperty
	property p_unmapped; i_rd && i_addr > 8'h60 |=> o_rd_data == 32'h0000_0000; endproperty
	property p_rst_clean; $rose(i_rst_b) |-> o_accept == '0 && o_rd_data == '0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	a_acc_idle: assert property (p_acc_idle) else $error("accept without offer");
	a_miss_zero: assert property (p_miss_zero) else $error("miss not zero");
	a_hit_range: assert property (p_hit_range) else $error("filter out of range");
	a_en_wr: assert property (p_en_wr) else $error("enable not written");
	a_protect: assert property (p_protect) else $error("choice changed while on");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	a_rst_clean: assert property (p_rst_clean) else $error("outputs after reset");
endmodule : can_filter_chk
bind can_acceptance_filter_control can_filter_chk #(.NUM_FILTERS(NUM_FILTERS)) u_chk (
	.i_sys_clk, .i_rst_b, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_rx, .o_accept);

// >>> can_acceptance_filter_control_test.sv
// Self-checking bench for the acceptance filter block.
`timescale 1ns/1ps
module can_acceptance_filter_control_test;
	logic clk = 0, rst_b = 0, wr = 0, rd = 0, req = 0, p_rd = 0, p_acc = 0;
	logic [7:0] addr = '0;
	logic [31:0] wdata = '0, rdata, a_id, seed = 32'h435b_2a94;
	logic [28:0] id = '0;
	logic [31:0] exp_rd[$];
	can_filter_pkg::rx_id_t rx;
	can_filter_pkg::accept_t acc;
	can_filter_pkg::accept_t exp_acc[$];
	int n_mismatch = 0, compares = 0, cyc = 0;
	can_acceptance_filter_control DUT (.i_sys_clk(clk), .i_rst_b(rst_b), .i_addr(addr),
		.i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_rx(rx), .o_accept(acc));
	can_rx_model u_rx (.i_sys_clk(clk), .i_rst_b(rst_b), .i_req(req), .i_id(id), .o_rx(rx));
	initial forever #50 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction : xs
	task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp_rd
	task automatic cmp_acc(input can_filter_pkg::accept_t g, input can_filter_pkg::accept_t e);
		cmp_rd({21'h0, g}, {21'h0, e});
	endtask : cmp_acc
	task automatic print_verdict();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict
	// Kind 0 idles, 1 writes, 2 reads, 3 offers an identifier; strobes last one cycle.
	task automatic op(input logic [1:0] k, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= k == 2'h1;
		rd <= k == 2'h2;
		req <= k == 2'h3;
		addr <= a;
		wdata <= d;
		id <= d[28:0];
	endtask : op
	task automatic rd_e(input logic [7:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		op(2'h2, a, 32'h0);
	endtask : rd_e
	task automatic rx_e(input logic [28:0] i, input can_filter_pkg::accept_t e);
		exp_acc.push_back(e);
		op(2'h3, 8'h00, {3'h0, i});
	endtask : rx_e
	always @(negedge clk) begin
		if (p_rd) cmp_rd(rdata, exp_rd.pop_front());
		if (p_acc) cmp_acc(acc, exp_acc.pop_front());
		p_rd = rd;
		p_acc = rx.valid;
		cyc++;
		if (cyc > 500) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		for (int r = 0; r < 4; r++) rd_e(8'(r * 4), 32'h0);
		seed = xs(seed);
		a_id = seed;
		op(2'h1, 8'h14, 32'h1FFF_FFFF);
		op(2'h1, 8'h20, a_id);
		op(2'h1, 8'h00, 32'h0000_85BF);
		rd_e(8'h00, 32'h0000_85BF);
		op(2'h1, 8'h00, 32'h0000_8080);
		rd_e(8'h00, 32'h0000_85BF);
		rx_e(a_id[28:0], {1'b1, 5'h1F, 5'h00});
		rx_e(a_id[28:0] ^ 29'h1, {1'b1, 5'h05, 5'h01});
		op(2'h1, 8'h00, 32'h0);
		rx_e(a_id[28:0], '0);
		rd_e(8'hF0, 32'h0);
		for (int m = 0; m < 4; m++) begin
			op(2'h1, 8'(16 + 4 * m), 32'h1 << m);
			op(2'h1, 8'h08, 32'h0);
			op(2'h1, 8'h08, {16'h0, 1'b1, 2'(m), 5'(m + 20), 8'h0});
			rd_e(8'h08, {16'h0, 1'b1, 2'(m), 5'(m + 20), 8'h0});
			rx_e(29'h1 << m, '0);
			rx_e(~(29'h1 << m), {1'b1, 5'(m + 20), 5'h09});
		end
		op(2'h0, 8'h00, 32'h0);
		repeat (3) @(posedge clk);
		print_verdict();
	end
endmodule : can_acceptance_filter_control_test
